// [pkg/pwg_pkg.sv]
// Shared constants and types for host and device ends.
// Assumes one 100 MHz clock.
package pwg_pkg;
    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
    localparam logic [7:0] CMD_STORE_ALL = 8'h15;
    localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
    localparam logic [7:0] CMD_BCAST_MASK = 8'hE4;
    localparam logic [7:0] CMD_CMD_PLUS = 8'hF3;
    localparam logic [7:0] CMD_NV_UNLOCK = 8'hF4;
    // ----------------------------------------
    // Page and lock codes
    // ----------------------------------------
    localparam logic [7:0] PAGE_LAST = 8'h07;
    localparam logic [7:0] PAGE_BCAST = 8'hFF;
    localparam logic [7:0] LOCK_L1 = 8'h80;
    localparam logic [7:0] LOCK_L2 = 8'h40;
    localparam logic [7:0] LOCK_NONE = 8'h00;
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [7:0] RST_LOCK = 8'h00;
    // ----------------------------------------
    // Number formats
    // ----------------------------------------
    localparam logic [4:0] VOUT_EXP = 5'h13;
    localparam logic [15:0] VOUT_MODE_WORD = {11'h000, VOUT_EXP};
    // ----------------------------------------
    // Link timing
    // ----------------------------------------
    localparam int CLK_NS = 10;
    localparam int LK_HALF_NS = 60;
    localparam logic [3:0] LK_HALF_CYC = 4'(LK_HALF_NS / CLK_NS);
    // ----------------------------------------
    // Host register map
    // ----------------------------------------
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_WDATA = 8'h04;
    localparam logic [7:0] A_GO = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0C;
    localparam logic [7:0] A_RDATA = 8'h10;
    localparam logic [7:0] A_DECODE = 8'h14;
    localparam logic [7:0] A_IRQ_STAT = 8'h18;
    localparam logic [7:0] A_IRQ_EN = 8'h1C;
    localparam logic [7:0] A_IRQ_CLR = 8'h20;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {LVL_NONE = 2'b00, LVL_TWO = 2'b01, LVL_ONE = 2'b10} pwg_lvl_t;
    typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_WAIT = 2'b01, HS_REL = 2'b10} pwg_hst_t;
endpackage

// [pkg/pwg_link_if.sv]
// Link between the command host and the page/write-guard device.
// Host makes lk_clk; both ends sync link signals in two flops.
`timescale 1ns/1ps
interface pwg_link_if;
    logic lk_clk;
    logic lk_req;
    logic lk_rd;
    logic [7:0] lk_cmd;
    logic [15:0] lk_wdata;
    logic lk_ack;
    logic [15:0] lk_rdata;
    logic lk_cml;
    logic lk_deny;
    modport host (output lk_clk, lk_req, lk_rd, lk_cmd, lk_wdata, input lk_ack, lk_rdata, lk_cml, lk_deny);
    modport dev (input lk_clk, lk_req, lk_rd, lk_cmd, lk_wdata, output lk_ack, lk_rdata, lk_cml, lk_deny);
endinterface

// [design/pwg_fmt.sv]
// Splits a word into exponent and mantissa.
// Assumes the caller flags voltage words.
`timescale 1ns/1ps
module pwg_fmt (
    // Raw word
    input wire logic [15:0] word,
    input wire logic volt,
    // Decoded fields
    output logic [7:0] exp_o,
    output logic [16:0] mant_o
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    always_comb
    begin
        if (volt)
        begin
            exp_o = {{3{pwg_pkg::VOUT_EXP[4]}}, pwg_pkg::VOUT_EXP};
            mant_o = {1'b0, word};
        end
        else
        begin
            exp_o = {{3{word[15]}}, word[15:11]};
            mant_o = {{6{word[10]}}, word[10:0]};
        end
    end
endmodule // pwg_fmt

// [design/pwg_dev.sv]
// Device end: channel page decode, broadcast gating and write lock.
// Assumes the host makes the link clock and holds requests until acked.
// Summary of operation
// - Short format: 5-bit exponent, 11-bit mantissa
// - Voltage words unsigned, exponent fixed minus thirteen
// - Register words are 16 or 8 bit fields
// - Pages zero to seven pick one channel
// - Broadcast page: only three commands reach channels
// - Broadcast reaches only channels enabled in mask
// - Paged read on broadcast page flags fault
// - Unsupported broadcast write dropped, fault flagged
// - Reads always succeed under any lock
// - Level one: only lock, page, unlock, store
// - Level two adds operation, pointer, mask, clear
// - Zero lock permits all; other codes reserved
// - High protect pin forces at least level two
// - Effective level is stricter of pin, register
// - Lock level can be saved and restored
// - Mask bit n governs channel n
`timescale 1ns/1ps
module pwg_dev (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link to host
    pwg_link_if.dev lk,
    // Protect pin and broadcast mask
    input wire logic wp_pin,
    input wire logic [7:0] bcast_mask,
    // Nonvolatile image of the lock level
    input wire logic nv_load,
    input wire logic [7:0] nv_lock_value,
    output logic nv_store,
    output logic [7:0] nv_lock_image,
    // Channel side
    input wire logic [15:0] chan_rdata,
    output logic [7:0] rd_page,
    output logic [8:0] wr_stb,
    output logic [7:0] wr_cmd,
    output logic [15:0] wr_data,
    // Status
    output logic [1:0] lock_level,
    output logic cml_fault
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] clk_s;
        logic clk_d;
        logic [1:0] req_s;
        logic [1:0] rd_s;
        logic [1:0][7:0] cmd_s;
        logic [1:0][15:0] wd_s;
        logic [1:0] wp_s;
        logic [7:0] page;
        logic [7:0] lock;
        logic ack;
        logic [15:0] rdata;
        logic cml;
        logic deny;
        logic [8:0] stb;
        logic [7:0] cmd;
        logic [15:0] wdata;
        logic store;
        logic fault;
    } pwg_dev_st_t;

    pwg_dev_st_t st_ff;
    pwg_dev_st_t nxt_st;
    pwg_pkg::pwg_lvl_t lvl;
    logic [7:0] c;
    logic [15:0] wd;
    logic bc;
    logic set_f;
    logic clr;

    // ----------------------------------------
    // Command classes
    // ----------------------------------------
    function automatic logic is_paged(input logic [7:0] k);
        case (k)
            pwg_pkg::CMD_PAGE, pwg_pkg::CMD_WRITE_LOCK, pwg_pkg::CMD_STORE_ALL,
            pwg_pkg::CMD_NV_UNLOCK, pwg_pkg::CMD_BCAST_MASK, pwg_pkg::CMD_CMD_PLUS,
            pwg_pkg::CMD_VOUT_MODE: is_paged = 1'b0;
            default: is_paged = 1'b1;
        endcase
    endfunction

    function automatic logic bcast_ok(input logic [7:0] k);
        case (k)
            pwg_pkg::CMD_CLEAR_FAULTS, pwg_pkg::CMD_OPERATION, pwg_pkg::CMD_ON_OFF: bcast_ok = 1'b1;
            default: bcast_ok = 1'b0;
        endcase
    endfunction

    // Stricter of pin and register; reserved codes act as no lock
    function automatic pwg_pkg::pwg_lvl_t lvl_of(input logic [7:0] lock, input logic pin);
        if (lock == pwg_pkg::LOCK_L1)
            lvl_of = pwg_pkg::LVL_ONE;
        else if (lock == pwg_pkg::LOCK_L2 || pin)
            lvl_of = pwg_pkg::LVL_TWO;
        else
            lvl_of = pwg_pkg::LVL_NONE;
    endfunction

    function automatic logic allowed(input logic [7:0] k, input pwg_pkg::pwg_lvl_t l);
        logic base;
        logic extra;
        base = k == pwg_pkg::CMD_WRITE_LOCK || k == pwg_pkg::CMD_PAGE
            || k == pwg_pkg::CMD_NV_UNLOCK || k == pwg_pkg::CMD_STORE_ALL;
        extra = k == pwg_pkg::CMD_OPERATION || k == pwg_pkg::CMD_CMD_PLUS
            || k == pwg_pkg::CMD_BCAST_MASK || k == pwg_pkg::CMD_CLEAR_FAULTS;
        case (l)
            pwg_pkg::LVL_NONE: allowed = 1'b1;
            pwg_pkg::LVL_ONE: allowed = base;
            pwg_pkg::LVL_TWO: allowed = base | extra;
            default: allowed = 1'b0;
        endcase
    endfunction

    // Bit 8: unpaged command strobe
    function automatic logic [8:0] stb_of(input logic [7:0] k, input logic [7:0] pg, input logic [7:0] msk);
        if (!is_paged(k))
            stb_of = 9'h100;
        else if (pg == pwg_pkg::PAGE_BCAST)
            stb_of = {1'b0, msk};
        else if (pg <= pwg_pkg::PAGE_LAST)
            stb_of = {1'b0, 8'h01 << pg[2:0]};
        else
            stb_of = 9'h000;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        lvl = lvl_of(st_ff.lock, st_ff.wp_s[1]);
        c = st_ff.cmd_s[1];
        wd = st_ff.wd_s[1];
        bc = st_ff.page == pwg_pkg::PAGE_BCAST;
        set_f = 1'b0;
        clr = 1'b0;
        // Link signals pass two flops
        nxt_st.clk_s = {st_ff.clk_s[0], lk.lk_clk};
        nxt_st.clk_d = st_ff.clk_s[1];
        nxt_st.req_s = {st_ff.req_s[0], lk.lk_req};
        nxt_st.rd_s = {st_ff.rd_s[0], lk.lk_rd};
        nxt_st.cmd_s = {st_ff.cmd_s[0], lk.lk_cmd};
        nxt_st.wd_s = {st_ff.wd_s[0], lk.lk_wdata};
        nxt_st.wp_s = {st_ff.wp_s[0], wp_pin};
        nxt_st.stb = 9'h000;
        nxt_st.store = 1'b0;
        if (nv_load)
            nxt_st.lock = nv_lock_value;
        // Act on link clock rise; data settled a half period
        if (st_ff.clk_s[1] && !st_ff.clk_d)
        begin
            if (st_ff.req_s[1] && !st_ff.ack)
            begin
                nxt_st.ack = 1'b1;
                nxt_st.deny = 1'b0;
                nxt_st.rdata = chan_rdata;
                if (st_ff.rd_s[1])
                begin
                    case (c)
                        pwg_pkg::CMD_PAGE: nxt_st.rdata = {8'h00, st_ff.page};
                        pwg_pkg::CMD_WRITE_LOCK: nxt_st.rdata = {8'h00, st_ff.lock};
                        pwg_pkg::CMD_BCAST_MASK: nxt_st.rdata = {8'h00, bcast_mask};
                        pwg_pkg::CMD_VOUT_MODE: nxt_st.rdata = pwg_pkg::VOUT_MODE_WORD;
                        default: nxt_st.rdata = chan_rdata;
                    endcase
                    if (bc && is_paged(c))
                        set_f = 1'b1;
                end
                else if (!allowed(c, lvl))
                    nxt_st.deny = 1'b1;
                else if (bc && is_paged(c) && !bcast_ok(c))
                    set_f = 1'b1;
                else
                begin
                    case (c)
                        pwg_pkg::CMD_PAGE: nxt_st.page = wd[7:0];
                        pwg_pkg::CMD_WRITE_LOCK: nxt_st.lock = wd[7:0];
                        pwg_pkg::CMD_STORE_ALL: nxt_st.store = 1'b1;
                        default: nxt_st.stb = stb_of(c, st_ff.page, bcast_mask);
                    endcase
                    nxt_st.cmd = c;
                    nxt_st.wdata = wd;
                    clr = c == pwg_pkg::CMD_CLEAR_FAULTS;
                end
                nxt_st.cml = set_f;
            end
            else if (!st_ff.req_s[1] && st_ff.ack)
                nxt_st.ack = 1'b0;
        end
        // A new fault in the clearing cycle survives
        nxt_st.fault = set_f | (st_ff.fault & ~clr);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
            st_ff.page <= pwg_pkg::RST_PAGE;
            st_ff.lock <= pwg_pkg::RST_LOCK;
        end
        else
            st_ff <= nxt_st;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign lk.lk_ack = st_ff.ack;
    assign lk.lk_rdata = st_ff.rdata;
    assign lk.lk_cml = st_ff.cml;
    assign lk.lk_deny = st_ff.deny;
    assign nv_store = st_ff.store;
    assign nv_lock_image = st_ff.lock;
    assign rd_page = st_ff.page;
    assign wr_stb = st_ff.stb;
    assign wr_cmd = st_ff.cmd;
    assign wr_data = st_ff.wdata;
    assign lock_level = lvl;
    assign cml_fault = st_ff.fault;
endmodule // pwg_dev

// [design/pwg_host.sv]
// Host end: AXI4-Lite command registers driving one link transfer at a time.
// Assumes every request is answered; else the host stays busy.
`timescale 1ns/1ps
module pwg_host (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Interrupt
    output logic irq,
    // Link to device
    pwg_link_if.host lk
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] div;
        logic lkc;
        logic req;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] wd;
        logic [1:0] ack_s;
        logic [1:0][15:0] rd_s;
        logic [1:0] cml_s;
        logic [1:0] deny_s;
        pwg_pkg::pwg_hst_t fsm;
        logic go;
        logic aw_got;
        logic [7:0] aw_a;
        logic w_got;
        logic [31:0] w_d;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [9:0] rg_cmd;
        logic [15:0] rg_wd;
        logic [15:0] res;
        logic res_cml;
        logic res_deny;
        logic [2:0] ist;
        logic [2:0] ien;
    } pwg_host_st_t;

    pwg_host_st_t st_ff;
    pwg_host_st_t nxt_st;
    logic tick;
    logic fall;
    logic bad_lock;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [7:0] dexp;
    logic [16:0] dmant;

    pwg_fmt u_fmt (
        .word(st_ff.res),
        .volt(st_ff.rg_cmd[9]),
        .exp_o(dexp),
        .mant_o(dmant)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        ev = 3'h0;
        clr = 3'h0;
        // Link clock; requests move on its fall
        tick = st_ff.div == pwg_pkg::LK_HALF_CYC - 4'h1;
        fall = tick && st_ff.lkc;
        nxt_st.div = tick ? 4'h0 : st_ff.div + 4'h1;
        nxt_st.lkc = tick ? ~st_ff.lkc : st_ff.lkc;
        nxt_st.ack_s = {st_ff.ack_s[0], lk.lk_ack};
        nxt_st.rd_s = {st_ff.rd_s[0], lk.lk_rdata};
        nxt_st.cml_s = {st_ff.cml_s[0], lk.lk_cml};
        nxt_st.deny_s = {st_ff.deny_s[0], lk.lk_deny};
        bad_lock = !st_ff.rg_cmd[8] && st_ff.rg_cmd[7:0] == pwg_pkg::CMD_WRITE_LOCK
            && st_ff.rg_wd[7:0] != pwg_pkg::LOCK_NONE && st_ff.rg_wd[7:0] != pwg_pkg::LOCK_L1
            && st_ff.rg_wd[7:0] != pwg_pkg::LOCK_L2;
        // Write: address, data in any order
        if (awvalid && !st_ff.aw_got)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_a = awaddr;
        end
        if (wvalid && !st_ff.w_got)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_d = wdata;
        end
        if (st_ff.bvalid && bready)
            nxt_st.bvalid = 1'b0;
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = pwg_pkg::RESP_OKAY;
            case (st_ff.aw_a)
                pwg_pkg::A_CMD: nxt_st.rg_cmd = st_ff.w_d[9:0];
                pwg_pkg::A_WDATA: nxt_st.rg_wd = st_ff.w_d[15:0];
                pwg_pkg::A_GO: nxt_st.go = st_ff.fsm == pwg_pkg::HS_IDLE;
                pwg_pkg::A_IRQ_EN: nxt_st.ien = st_ff.w_d[2:0];
                pwg_pkg::A_IRQ_CLR: clr = st_ff.w_d[2:0];
                default: nxt_st.bresp = pwg_pkg::RESP_DECERR;
            endcase
        end
        // Read channel
        if (st_ff.rvalid && rready)
            nxt_st.rvalid = 1'b0;
        if (arvalid && !st_ff.rvalid)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = pwg_pkg::RESP_OKAY;
            case (araddr)
                pwg_pkg::A_CMD: nxt_st.rdata = {22'h00_0000, st_ff.rg_cmd};
                pwg_pkg::A_WDATA: nxt_st.rdata = {16'h0000, st_ff.rg_wd};
                pwg_pkg::A_STATUS:
                    nxt_st.rdata = {29'h0000_0000, st_ff.res_deny, st_ff.res_cml,
                        st_ff.go || st_ff.fsm != pwg_pkg::HS_IDLE};
                pwg_pkg::A_RDATA: nxt_st.rdata = {16'h0000, st_ff.res};
                pwg_pkg::A_DECODE: nxt_st.rdata = {dexp, 7'h00, dmant};
                pwg_pkg::A_IRQ_STAT: nxt_st.rdata = {29'h0000_0000, st_ff.ist};
                pwg_pkg::A_IRQ_EN: nxt_st.rdata = {29'h0000_0000, st_ff.ien};
                pwg_pkg::A_GO, pwg_pkg::A_IRQ_CLR: nxt_st.rdata = 32'h0000_0000;
                default:
                begin
                    nxt_st.rdata = 32'h0000_0000;
                    nxt_st.rresp = pwg_pkg::RESP_DECERR;
                end
            endcase
        end
        // Link transfer: four-phase request and acknowledge
        case (st_ff.fsm)
            pwg_pkg::HS_IDLE:
                if (st_ff.go && fall)
                begin
                    nxt_st.go = 1'b0;
                    if (bad_lock)
                    begin
                        // Reserved lock codes stay here
                        nxt_st.res_deny = 1'b1;
                        nxt_st.res_cml = 1'b0;
                        ev = 3'b101;
                    end
                    else
                    begin
                        nxt_st.req = 1'b1;
                        nxt_st.rd = st_ff.rg_cmd[8];
                        nxt_st.cmd = st_ff.rg_cmd[7:0];
                        nxt_st.wd = st_ff.rg_wd;
                        nxt_st.fsm = pwg_pkg::HS_WAIT;
                    end
                end
            pwg_pkg::HS_WAIT:
                if (st_ff.ack_s[1] && fall)
                begin
                    nxt_st.res = st_ff.rd_s[1];
                    nxt_st.res_cml = st_ff.cml_s[1];
                    nxt_st.res_deny = st_ff.deny_s[1];
                    nxt_st.req = 1'b0;
                    nxt_st.fsm = pwg_pkg::HS_REL;
                end
            pwg_pkg::HS_REL:
                if (!st_ff.ack_s[1])
                begin
                    nxt_st.fsm = pwg_pkg::HS_IDLE;
                    ev = {st_ff.res_deny, st_ff.res_cml, 1'b1};
                end
            default: nxt_st.fsm = pwg_pkg::HS_IDLE;
        endcase
        // Set beats clear in the same cycle
        nxt_st.ist = (st_ff.ist & ~clr) | ev;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign awready = !st_ff.aw_got;
    assign wready = !st_ff.w_got;
    assign bvalid = st_ff.bvalid;
    assign bresp = st_ff.bresp;
    assign arready = !st_ff.rvalid;
    assign rvalid = st_ff.rvalid;
    assign rdata = st_ff.rdata;
    assign rresp = st_ff.rresp;
    assign irq = |(st_ff.ist & st_ff.ien);
    assign lk.lk_clk = st_ff.lkc;
    assign lk.lk_req = st_ff.req;
    assign lk.lk_rd = st_ff.rd;
    assign lk.lk_cmd = st_ff.cmd;
    assign lk.lk_wdata = st_ff.wd;
endmodule // pwg_host

// [sim/pwg_link_sva.sv]
// Checker on the link between the host and device ends.
// Assumes one aclk domain; sits beside the link interface.
`timescale 1ns/1ps
module pwg_link_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link signals
    input wire logic lk_req,
    input wire logic lk_rd,
    input wire logic [7:0] lk_cmd,
    input wire logic [15:0] lk_wdata,
    input wire logic lk_ack,
    input wire logic [15:0] lk_rdata,
    input wire logic lk_cml,
    input wire logic lk_deny
);
    typedef struct packed {logic [7:0] pg; logic [7:0] lck;} pwg_cs_t;
    pwg_cs_t st_ff;
    pwg_cs_t nxt_st;
    logic paged;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------
    // Accepted page and lock
    // ------------
    // Lock loads from nv_load unseen here
    assign paged = !(lk_cmd inside {8'h00, 8'h10, 8'h15, 8'h20, 8'hE4, 8'hF3, 8'hF4});
    always_comb
    begin
        nxt_st = st_ff;
        if (lk_req && lk_ack && !lk_rd && !lk_deny && lk_cmd == 8'h00)
            nxt_st.pg = lk_wdata[7:0];
        if (lk_req && lk_ack && !lk_rd && !lk_deny && lk_cmd == 8'h10)
            nxt_st.lck = lk_wdata[7:0];
    end
    always_ff @(posedge aclk)
        st_ff <= !aresetn ? '0 : nxt_st;
    // ------------
    // Properties
    // ------------
    sequence s_wa; $rose(lk_ack) && !lk_rd; endsequence
    sequence s_ra; $rose(lk_ack) && lk_rd; endsequence
    property p_hold; lk_req && !lk_ack |=> lk_req; endproperty
    a_hold: assert property (p_hold) else $error("req dropped");
    property p_ans; $rose(lk_req) |-> ##[1:40] lk_ack; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_rnd; s_ra |-> !lk_deny; endproperty
    a_rnd: assert property (p_rnd) else $error("read refused");
    property p_vout; s_ra ##0 lk_cmd == 8'h20 |-> ##[0:1] lk_rdata == 16'h0013; endproperty
    a_vout: assert property (p_vout) else $error("vout word");
    property p_l1; s_wa ##0 st_ff.lck == 8'h80 && lk_cmd == 8'h01 |-> lk_deny; endproperty
    a_l1: assert property (p_l1) else $error("level one write");
    property p_free; s_wa ##0 lk_cmd inside {8'h00, 8'h10, 8'h15, 8'hF4} |-> !lk_deny; endproperty
    a_free: assert property (p_free) else $error("free write refused");
    property p_bcw; s_wa ##0 st_ff.pg == 8'hFF && paged && !(lk_cmd inside {8'h01, 8'h02, 8'h03}) && !lk_deny
        |-> lk_cml; endproperty
    a_bcw: assert property (p_bcw) else $error("bcast write no fault");
    property p_bcr; s_ra ##0 st_ff.pg == 8'hFF && paged |-> lk_cml; endproperty
    a_bcr: assert property (p_bcr) else $error("bcast read no fault");
endmodule // pwg_link_sva

// [sim/pmbus_page_and_write_guard_tb.sv]
// Bench: host and device on one link, driven over AXI4-Lite.
// Assumes 100 MHz aclk and synchronous active-low reset.
`timescale 1ns/1ps
module pmbus_page_and_write_guard_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic [31:0] wdata;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic wp_pin = 1'b0, nv_load = 1'b0;
    logic [7:0] nv_lock_value;
    logic [7:0] bcast_mask;
    logic [15:0] chan_rdata = 16'hD280;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0] rdata;
    logic [8:0] wr_stb;
    logic [31:0] qr[$];
    logic [31:0] qs[$];
    logic [7:0] lv;
    int errors = 0;
    int tests_run = 0;
    pwg_link_if lk_if ();
    pwg_host pwg_host_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(),
        .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(), .rvalid(rvalid), .rready(1'b1), .irq(irq), .lk(lk_if));
    pwg_dev pwg_dev_i (.aclk(aclk), .aresetn(aresetn), .lk(lk_if), .wp_pin(wp_pin),
        .bcast_mask(bcast_mask), .nv_load(nv_load), .nv_lock_value(nv_lock_value), .nv_store(),
        .nv_lock_image(), .chan_rdata(chan_rdata), .rd_page(), .wr_stb(wr_stb), .wr_cmd(), .wr_data(),
        .lock_level(), .cml_fault());
    pwg_link_sva pwg_link_sva_i (.aclk(aclk), .aresetn(aresetn), .lk_req(lk_if.lk_req),
        .lk_rd(lk_if.lk_rd), .lk_cmd(lk_if.lk_cmd), .lk_wdata(lk_if.lk_wdata), .lk_ack(lk_if.lk_ack),
        .lk_rdata(lk_if.lk_rdata), .lk_cml(lk_if.lk_cml), .lk_deny(lk_if.lk_deny));
    always #5 aclk = ~aclk;
    // ------------
    // Checking
    // ------------
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        tests_run++;
        if (s !== x)
        begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, x, s);
        end
    endtask
    task automatic end_of_test();
        chk("strobes left", 32'h0000_0000, 32'(qs.size()));
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Empty queue pops X: stray strobe fails
    always @(negedge aclk)
    begin
        if (rvalid)
            chk("rdata", qr.pop_front(), rdata);
        if (wr_stb != 9'h000)
            chk("wr_stb", qs.pop_front(), 32'(wr_stb));
    end
    // ------------
    // Tasks
    // ------------
    task automatic step(inout int n);
        @(posedge aclk);
        #1;
        n++;
        if (n > 400)
        begin
            errors++;
            $display("[ERR] wait exp done got timeout");
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            step(n);
            if (!awready)
                awvalid <= 1'b0;
            if (!wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        step(n);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        int n = 0;
        qr.push_back(x);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            step(n);
            if (!arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        step(n);
    endtask
    task automatic op(input logic [9:0] c, input logic [15:0] d);
        int n = 0;
        wr(8'h00, 32'(c));
        wr(8'h04, 32'(d));
        wr(8'h08, 32'h0000_0000);
        while (irq !== 1'b1)
            step(n);
        wr(8'h20, 32'h0000_0007);
    endtask
    // ------------
    // Scenarios
    // ------------
    initial
    begin
        void'($urandom(48017));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(8'h1C, 32'h0000_0001);
        rd(8'h40, 32'h0000_0000);
        for (int p = 0; p < 8; p++)
        begin
            op(10'h000, 16'(p));
            qs.push_back(32'h0000_0001 << p);
            op(10'h001, 16'($urandom));
        end
        $display("pages done");
        lv = 8'($urandom) | 8'h01;
        bcast_mask <= lv;
        op(10'h000, 16'h00FF);
        for (int c = 1; c < 4; c++)
        begin
            qs.push_back(32'(lv));
            op(10'(c), 16'($urandom));
        end
        op(10'h030, 16'h1234);
        rd(8'h0C, 32'h0000_0002);
        op(10'h130, 16'h0000);
        rd(8'h0C, 32'h0000_0002);
        $display("broadcast done");
        op(10'h320, 16'h0000);
        rd(8'h14, 32'hF300_0013);
        op(10'h000, 16'h0000);
        op(10'h130, 16'h0000);
        rd(8'h10, 32'h0000_D280);
        rd(8'h14, 32'hFA00_0280);
        $display("formats done");
        for (int i = 0; i < 6; i++)
        begin
            lv = 8'(64 * (i % 3));
            wp_pin <= (i > 2);
            op(10'h010, 16'(lv));
            op(10'h110, 16'h0000);
            rd(8'h10, 32'(lv));
            if (lv != 8'h80)
                qs.push_back(32'h0000_0001);
            op(10'h001, 16'h0000);
            if (lv == 8'h00 && i < 3)
                qs.push_back(32'h0000_0001);
            op(10'h030, 16'h0000);
            rd(8'h0C, {29'h0, lv != 8'h00 || i > 2, 2'b00});
        end
        op(10'h010, 16'h0020);
        rd(8'h0C, 32'h0000_0004);
        wp_pin <= 1'b0;
        op(10'h010, 16'h0000);
        nv_lock_value <= 8'h80;
        nv_load <= 1'b1;
        @(posedge aclk);
        nv_load <= 1'b0;
        op(10'h110, 16'h0000);
        rd(8'h10, 32'h0000_0080);
        rd(8'h18, 32'h0000_0000);
        $display("lock done");
        end_of_test();
    end
endmodule // pmbus_page_and_write_guard_tb
